// ===== caf_pkg.sv
// Package for the consequent action filter: types and constants
package caf_pkg;

    // Persistence counts for frame alignment and alarm indication
    localparam int unsigned CAF_INFRAME_COUNT = 3;
    localparam int unsigned CAF_OOF_COUNT = 5;
    localparam int unsigned CAF_AIS_FRAMES = 3;
    localparam int unsigned CAF_CNT_W = 3;

    // Alignment-loss source selection
    typedef enum logic [1:0] {
        CAF_LOA_FRAME = 2'h0,
        CAF_LOA_MULTIFRAME = 2'h1,
        CAF_LOA_POINTER = 2'h3
    } caf_loa_sel_e;

    // Frame persistence states
    typedef enum logic {
        CAF_OOF = 1'b0,
        CAF_IN_FRAME = 1'b1
    } caf_frame_e;

    // Defects seen by the termination sink
    typedef struct packed {
        logic signal_loss_defect;
        logic trace_mismatch_defect;
        logic server_fail_in;
        logic code_group_fail_anomaly;
    } caf_tt_in_s;

    // Defects seen by the adaptation sink
    typedef struct packed {
        logic payload_mismatch_defect;
        logic multiframe_loss_defect;
        logic pointer_loss_defect;
        logic trail_fail_in;
        logic not_active;
    } caf_as_in_s;

    // Action requests
    typedef struct packed {
        logic tt_alarm_insert_req;
        logic trail_fail_out;
        logic code_group_fail_out;
        logic as_alarm_insert_req;
        logic server_fail_out;
        logic align_hunt_enable;
        logic port_trail_fail_out;
        logic so_alarm_insert_req;
    } caf_act_s;

    localparam caf_act_s CAF_ACT_RESET = '0;

endpackage

// ===== caf_filter.sv
// Consequent action filter: defect persistence and action requests
`timescale 1ns/1ns
module caf_filter
    import caf_pkg::*;
#(
    parameter int unsigned DATA_W = 8,
    parameter bit HAS_AIS_DETECT = 1'b1,
    parameter caf_loa_sel_e LOA_SEL = CAF_LOA_FRAME
) (
    input wire logic clock,                   // 20 MHz system clock
    input wire logic reset_n,                 // Synchronous reset, low
    input wire logic align_opportunity,       // Frame alignment opportunity strobe
    input wire logic frame_loss_anomaly,      // Alignment failed on opportunity
    input wire logic frame_tick,              // One pulse per frame
    input wire logic alarm_indication_anomaly, // Alarm pattern seen this frame
    input wire caf_tt_in_s tt_in,             // Termination sink defects
    input wire caf_as_in_s as_in,             // Adaptation sink defects
    input wire logic so_server_fail_in,       // Server fail into adaptation source
    input wire logic [DATA_W-1:0] rx_data,    // Received traffic word
    output caf_act_s act,                     // Registered action requests
    output logic frame_loss_defect,           // Out-of-frame state
    output logic alarm_indication_defect,     // Filtered alarm defect
    output logic [DATA_W-1:0] tx_data         // Traffic or all-ones
);

    // Refuse parameters that the datapath or counters cannot serve
    if (DATA_W < 1) begin : g_bad_width
        $error("caf_filter: DATA_W must be at least 1");
    end
    if (CAF_INFRAME_COUNT < 1 || CAF_INFRAME_COUNT > (1 << CAF_CNT_W)) begin : g_bad_in_count
        $error("caf_filter: in-frame count does not fit the counter");
    end
    if (CAF_OOF_COUNT < 1 || CAF_OOF_COUNT > (1 << CAF_CNT_W)) begin : g_bad_out_count
        $error("caf_filter: out-of-frame count does not fit the counter");
    end
    if (CAF_AIS_FRAMES >= (1 << CAF_CNT_W)) begin : g_bad_ais_count
        $error("caf_filter: alarm persistence does not fit the counter");
    end
    if (LOA_SEL != CAF_LOA_FRAME && LOA_SEL != CAF_LOA_MULTIFRAME
        && LOA_SEL != CAF_LOA_POINTER) begin : g_bad_loa_sel
        $error("caf_filter: unknown alignment-loss source");
    end

    // Last count value before each persistence decision
    localparam logic [CAF_CNT_W-1:0] IN_LAST = CAF_CNT_W'(CAF_INFRAME_COUNT - 1);
    localparam logic [CAF_CNT_W-1:0] OUT_LAST = CAF_CNT_W'(CAF_OOF_COUNT - 1);
    localparam logic [CAF_CNT_W-1:0] AIS_LAST = CAF_CNT_W'(CAF_AIS_FRAMES);

    // Persistence state and output registers
    caf_frame_e frame_q, frame_d;
    logic [CAF_CNT_W-1:0] frm_cnt_q, frm_cnt_d;
    logic [CAF_CNT_W-1:0] ais_cnt_q, ais_cnt_d;
    logic ais_def_q, ais_def_d;
    caf_act_s act_q, act_d;
    logic [DATA_W-1:0] tx_q;

    // Combinational terms
    wire logic [DATA_W-1:0] tx_d;
    logic loa;
    logic ais_term;
    logic adapt_fail;

    // Frame persistence machine
    always_comb begin
        frame_d = frame_q;
        frm_cnt_d = frm_cnt_q;
        // Anomaly counts only on an opportunity
        if (align_opportunity) begin
            unique case (frame_q)
                CAF_OOF: begin
                    if (frame_loss_anomaly) begin
                        // A failed opportunity restarts the clean run
                        frm_cnt_d = '0;
                    end else if (frm_cnt_q == IN_LAST) begin
                        frame_d = CAF_IN_FRAME;
                        frm_cnt_d = '0;
                    end else begin
                        frm_cnt_d = frm_cnt_q + 1'b1;
                    end
                end
                CAF_IN_FRAME: begin
                    if (!frame_loss_anomaly) begin
                        // A clean opportunity restarts the failed run
                        frm_cnt_d = '0;
                    end else if (frm_cnt_q == OUT_LAST) begin
                        frame_d = CAF_OOF;
                        frm_cnt_d = '0;
                    end else begin
                        frm_cnt_d = frm_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // Frame state register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            frame_q <= CAF_OOF;
            frm_cnt_q <= '0;
        end else begin
            frame_q <= frame_d;
            frm_cnt_q <= frm_cnt_d;
        end
    end

    // Defect flag is the out-of-frame state
    assign frame_loss_defect = (frame_q == CAF_OOF);

    // Alarm indication persistence over frames
    always_comb begin
        ais_cnt_d = ais_cnt_q;
        ais_def_d = ais_def_q;
        // Anomaly counts only on a frame tick
        if (frame_tick) begin
            if (!alarm_indication_anomaly) begin
                // One clean frame ends the defect at once
                ais_cnt_d = '0;
                ais_def_d = 1'b0;
            end else if (ais_cnt_q == AIS_LAST) begin
                // Counter holds; defect stays while the anomaly lasts
                ais_def_d = 1'b1;
            end else begin
                ais_cnt_d = ais_cnt_q + 1'b1;
            end
        end
    end

    // Alarm persistence register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ais_cnt_q <= '0;
            ais_def_q <= 1'b0;
        end else begin
            ais_cnt_q <= ais_cnt_d;
            ais_def_q <= ais_def_d;
        end
    end

    // Filtered alarm defect to the port
    assign alarm_indication_defect = ais_def_q;

    // Alignment loss source for this adaptation
    always_comb begin
        unique case (LOA_SEL)
            CAF_LOA_MULTIFRAME: loa = as_in.multiframe_loss_defect;
            CAF_LOA_POINTER: loa = as_in.pointer_loss_defect;
            default: loa = frame_loss_defect;
        endcase
    end

    // Own alarm detector, or the upstream trail fail in its place
    assign ais_term = HAS_AIS_DETECT ? ais_def_q : as_in.trail_fail_in;

    // Terms shared by sink insertion and server fail
    assign adapt_fail = as_in.payload_mismatch_defect
        | loa
        | ais_term;

    // Action request equations
    always_comb begin
        // Termination sink
        act_d.tt_alarm_insert_req = ais_def_q
            | tt_in.signal_loss_defect;
        act_d.trail_fail_out = tt_in.server_fail_in
            | tt_in.signal_loss_defect
            | tt_in.trace_mismatch_defect;
        // Adaptation source
        act_d.so_alarm_insert_req = so_server_fail_in;
        // Adaptation sink
        act_d.as_alarm_insert_req = adapt_fail | as_in.not_active;
        act_d.server_fail_out = adapt_fail;
        // Block-coded line
        act_d.code_group_fail_out = tt_in.code_group_fail_anomaly;
        act_d.align_hunt_enable = frame_loss_defect;
        // Port state toward management
        act_d.port_trail_fail_out = frame_loss_defect
            | as_in.trail_fail_in
            | as_in.not_active;
    end

    // All-ones insertion, one gate per traffic bit
    for (genvar b = 0; b < DATA_W; b++) begin : g_insert
        assign tx_d[b] = act_d.as_alarm_insert_req | rx_data[b];
    end

    // Action request register, one stage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            act_q <= CAF_ACT_RESET;
        end else begin
            act_q <= act_d;
        end
    end

    // Traffic register, quiet in reset
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    // Registered outputs to the ports
    assign act = act_q;
    assign tx_data = tx_q;

endmodule

// ===== caf_filter_properties.sv
// Port assertions for the consequent action filter
`timescale 1ns/1ns
module caf_filter_properties
    import caf_pkg::*;
#(parameter int unsigned DATA_W = 8) (
    input wire logic clock, // Clock
    input wire logic reset_n, // Reset
    input wire caf_tt_in_s tt_in, // Sink
    input wire caf_as_in_s as_in, // Adapt
    input wire logic so_server_fail_in, // Source
    input wire logic [DATA_W-1:0] rx_data, // Data
    input wire caf_act_s act, // Actions
    input wire logic frame_loss_defect, // Frame
    input wire logic alarm_indication_defect, // Alarm
    input wire logic [DATA_W-1:0] tx_data // Data
);
    logic [1:0] live_q;
    wire as_fail = as_in.payload_mismatch_defect | alarm_indication_defect | frame_loss_defect;
    // Checks wait two edges after reset leaves, so $past sees no reset state
    always_ff @(posedge clock) live_q <= reset_n ? {live_q[0], 1'b1} : 2'h0;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n || !live_q[1]);
    tt_alarm_a: assert property (
        act.tt_alarm_insert_req == $past(tt_in.signal_loss_defect | alarm_indication_defect))
        else $error("tt alarm");
    so_alarm_a: assert property (
        act.so_alarm_insert_req == $past(so_server_fail_in)) else $error("so alarm");
    as_alarm_a: assert property (
        act.as_alarm_insert_req == $past(as_fail | as_in.not_active)) else $error("as alarm");
    server_fail_a: assert property (
        act.server_fail_out == $past(as_fail)) else $error("server fail");
    trail_fail_a: assert property (
        act.trail_fail_out == $past(tt_in.server_fail_in | tt_in.signal_loss_defect
        | tt_in.trace_mismatch_defect)) else $error("trail fail");
    code_fail_a: assert property (
        act.code_group_fail_out == $past(tt_in.code_group_fail_anomaly)) else $error("cgf");
    port_fail_a: assert property (
        act.port_trail_fail_out == $past(frame_loss_defect | as_in.trail_fail_in
        | as_in.not_active)) else $error("port fail");
    align_hunt_a: assert property (
        act.align_hunt_enable == $past(frame_loss_defect)) else $error("align hunt");
    all_ones_a: assert property (
        tx_data == (act.as_alarm_insert_req ? '1 : $past(rx_data))) else $error("tx data");
endmodule
bind caf_filter caf_filter_properties #(.DATA_W(DATA_W)) u_props (.clock, .reset_n, .tt_in,
    .as_in, .so_server_fail_in, .rx_data, .act, .frame_loss_defect, .alarm_indication_defect,
    .tx_data);

// ===== caf_pacer.sv
// Upstream pacing model: alignment opportunities and frame ticks
`timescale 1ns/1ns
module caf_pacer (
    input wire logic clock, // Clock
    input wire logic reset_n, // Reset
    output logic pulse // Every fourth cycle
);
    logic [1:0] cnt_q;
    // Free-running count, quiet in reset
    always_ff @(posedge clock) cnt_q <= reset_n ? cnt_q + 2'h1 : 2'h0;
    assign pulse = cnt_q == 2'h3;
endmodule

// ===== caf_filter_bench.sv
// Self-checking bench for the consequent action filter
`timescale 1ns/1ns
module caf_filter_bench;
    import caf_pkg::*;
    logic clock = 0, reset_n = 0, pulse, fla = 0, aia = 0, so = 0, fld, aid;
    caf_tt_in_s tt = '0;
    caf_as_in_s as_i = '0;
    caf_act_s act;
    logic [7:0] rx = 8'h5a, tx;
    int fail_count = 0, samples_checked = 0;
    // Inputs {sink, adapt, source} and expected actions
    logic [17:0] tbl [9] = '{{4'h8, 5'h00, 1'b0, 8'hc0}, {4'h4, 5'h00, 1'b0, 8'h40},
        {4'h2, 5'h00, 1'b0, 8'h40}, {4'h1, 5'h00, 1'b0, 8'h20}, {4'h0, 5'h10, 1'b0, 8'h18},
        {4'h0, 5'h0c, 1'b0, 8'h00}, {4'h0, 5'h02, 1'b0, 8'h02}, {4'h0, 5'h01, 1'b0, 8'h12},
        {4'h0, 5'h00, 1'b1, 8'h01}};
    caf_pacer u_caf_pacer (.clock(clock), .reset_n(reset_n), .pulse(pulse));
    caf_filter u_caf_filter (.clock(clock), .reset_n(reset_n), .align_opportunity(pulse),
        .frame_loss_anomaly(fla), .frame_tick(pulse), .alarm_indication_anomaly(aia),
        .tt_in(tt), .as_in(as_i), .so_server_fail_in(so), .rx_data(rx), .act(act),
        .frame_loss_defect(fld), .alarm_indication_defect(aid), .tx_data(tx));
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Wait for n pulse edges, then let updates land
    task automatic opp(int n);
        repeat (n) @(posedge clock iff pulse);
        #1;
    endtask
    task automatic wrap_up;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #25 clock = ~clock;
    // Cut a hang short
    initial begin
        repeat (1000) @(posedge clock);
        fail_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1;
        opp(2);
        chk("oof", fld, 8'h01);
        chk("act", act, 8'h1e);
        opp(1);
        chk("oof", fld, 8'h00);
        @(posedge clock);
        #1 chk("act", act, 8'h00);
        foreach (tbl[i]) begin
            @(posedge clock);
            {tt, as_i, so} <= tbl[i][17:8];
            rx <= rx + 8'h11;
            @(posedge clock);
            #1 chk("act", act, tbl[i][7:0]);
            chk("tx", tx, tbl[i][4] ? 8'hff : rx);
        end
        @(posedge clock);
        {tt, as_i, so} <= '0;
        aia <= 1;
        opp(3);
        chk("ais", aid, 8'h00);
        opp(1);
        chk("ais", aid, 8'h01);
        @(posedge clock);
        #1 chk("act", act, 8'h98);
        chk("tx", tx, 8'hff);
        @(posedge clock);
        aia <= 0;
        fla <= 1;
        opp(1);
        chk("ais", aid, 8'h00);
        opp(3);
        @(posedge clock);
        fla <= 0;
        opp(1);
        @(posedge clock);
        fla <= 1;
        opp(4);
        chk("oof", fld, 8'h00);
        opp(1);
        chk("oof", fld, 8'h01);
        @(posedge clock);
        reset_n <= 0;
        @(posedge clock);
        #1 chk("rst", {fld, aid, tx[5:0]}, 8'h80);
        chk("rst", act, 8'h00);
        wrap_up();
    end
endmodule
